/* File: pkg/sck_defs.svh */
// register offsets, field positions and reset values of the stop-mode clock keep block
`ifndef SCK_DEFS_SVH
`define SCK_DEFS_SVH

// ------------------------------------------------------------------
// register word offsets
// ------------------------------------------------------------------
`define SCK_OFS_KEEP_FIRST   8'h10
`define SCK_OFS_KEEP_SECOND  8'h11

// ------------------------------------------------------------------
// first keep register fields
// ------------------------------------------------------------------
`define SCK_BIT_TIMER_A_CH0  15
`define SCK_BIT_TIMER_A_CH1  14
`define SCK_BIT_TIMER_A_CH2  13
`define SCK_BIT_TIMER_A_CH3  12
`define SCK_BIT_PORT_A       6
`define SCK_BIT_PORT_B       5
`define SCK_BIT_PORT_C       4
`define SCK_BIT_PORT_D       3
`define SCK_BIT_PORT_E       2
`define SCK_BIT_PORT_F       1
`define SCK_MASK_FIRST       16'hF07E

// ------------------------------------------------------------------
// second keep register fields
// ------------------------------------------------------------------
`define SCK_BIT_CONVERTER_B  14
`define SCK_BIT_CONVERTER_A  13
`define SCK_BIT_SERIAL_IF0   12
`define SCK_BIT_SERIAL_IF1   11
`define SCK_BIT_QUEUED_SPI0  9
`define SCK_MASK_SECOND      16'h7A00

// ------------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------------
`define SCK_RST_KEEP         16'h0000
`define SCK_RDATA_IDLE       16'h0000
`define SCK_NUM_PERIPH       15

`endif

/* File: pkg/sck_pkg.sv */
// types shared by the stop-mode clock keep block
package sck_pkg;
   typedef enum logic [1:0] {
      SCK_RUN,
      SCK_STOP,
      SCK_WAKE
   } sck_mode_t;
endpackage

/* File: design/sck_stop_keep.sv */
// stop-mode clock keep registers and per-peripheral clock gate enables
//
// Operation
// - on stop entry each peripheral clock stops unless its keep bit is set
// - keep bit 1 keeps the clock in stop, 0 stops it; needs enable
// - clock enable wins: enable 0 means clock off in every mode
// - no bus access completes to a peripheral whose clock is gated off
// - interrupt from a kept peripheral returns system to run mode
// - second keep register sits at word offset 11h
// - first register bits 3,2,1 keep ports D, E, F clocks
// - second register bits 14,13 keep converters B and A
// - second register bits 12,11 keep serial interfaces 0 and 1
// - second register bit 9 keeps queued SPI 0
// - reserved bits read zero and are read-only
// - first keep register sits at word offset 10h
// - first register bits 15..12 timer A ch0..3, bits 6..4 ports A..C
//
// peripheral index order on the vector ports:
//  0..3 timer A ch0..3, 4..9 ports A..F, 10 converter B, 11 converter A,
//  12 serial if0, 13 serial if1, 14 queued spi0
`timescale 1ns/10ps
`include "sck_defs.svh"

module sck_stop_keep #(
   parameter int NUM_PERIPH = `SCK_NUM_PERIPH
)(
   // clock and reset
   input  wire logic                  SYS_CLK_I,
   input  wire logic                  RST_N_I,
   // peripheral register bus
   input  wire logic                  BUS_SEL_I,
   input  wire logic                  BUS_WR_I,
   input  wire logic [7:0]            BUS_ADDR_I,
   input  wire logic [15:0]           BUS_WDATA_I,
   output logic      [15:0]           BUS_RDATA_O,
   output logic                       BUS_ACK_O,
   // power mode
   input  wire logic                  STOP_REQ_I,
   input  wire logic [NUM_PERIPH-1:0] PERIPH_IRQ_I,
   output logic                       STOP_MODE_O,
   output logic                       WAKEUP_O,
   // per-peripheral clock control
   input  wire logic [NUM_PERIPH-1:0] PERIPHERAL_CLOCK_ENABLE_I,
   input  wire logic [NUM_PERIPH-1:0] PERIPH_SEL_I,
   output logic      [NUM_PERIPH-1:0] CLK_GATE_EN_O,
   output logic      [NUM_PERIPH-1:0] PERIPH_ACCESS_EN_O
);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [15:0]           stop_clock_keep_first;
   logic [15:0]           stop_clock_keep_second;
   logic [NUM_PERIPH-1:0] keep_vec;
   logic [NUM_PERIPH-1:0] next_gate;
   logic                  next_wake;
   logic                  hit_first;
   logic                  hit_second;
   sck_pkg::sck_mode_t    mode;

   assign hit_first  = BUS_SEL_I && (BUS_ADDR_I == `SCK_OFS_KEEP_FIRST);
   assign hit_second = BUS_SEL_I && (BUS_ADDR_I == `SCK_OFS_KEEP_SECOND);

   // reserved positions masked off on write, so they always read zero
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         stop_clock_keep_first  <= `SCK_RST_KEEP;
         stop_clock_keep_second <= `SCK_RST_KEEP;
      end
      else if (BUS_WR_I)
      begin
         if (hit_first)
            stop_clock_keep_first <= BUS_WDATA_I & `SCK_MASK_FIRST;
         if (hit_second)
            stop_clock_keep_second <= BUS_WDATA_I & `SCK_MASK_SECOND;
      end
   end

   // unmapped offsets still ack with zero so the bus never hangs
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         BUS_RDATA_O <= `SCK_RDATA_IDLE;
         BUS_ACK_O   <= 1'b0;
      end
      else
      begin
         BUS_ACK_O <= BUS_SEL_I;
         if (BUS_SEL_I && !BUS_WR_I && hit_first)
            BUS_RDATA_O <= stop_clock_keep_first;
         else if (BUS_SEL_I && !BUS_WR_I && hit_second)
            BUS_RDATA_O <= stop_clock_keep_second;
         else
            BUS_RDATA_O <= `SCK_RDATA_IDLE;
      end
   end

   // ------------------------------------------------------------------
   // field to peripheral mapping
   // ------------------------------------------------------------------
   always_comb
   begin
      keep_vec     = '0;
      keep_vec[0]  = stop_clock_keep_first[`SCK_BIT_TIMER_A_CH0];
      keep_vec[1]  = stop_clock_keep_first[`SCK_BIT_TIMER_A_CH1];
      keep_vec[2]  = stop_clock_keep_first[`SCK_BIT_TIMER_A_CH2];
      keep_vec[3]  = stop_clock_keep_first[`SCK_BIT_TIMER_A_CH3];
      keep_vec[4]  = stop_clock_keep_first[`SCK_BIT_PORT_A];
      keep_vec[5]  = stop_clock_keep_first[`SCK_BIT_PORT_B];
      keep_vec[6]  = stop_clock_keep_first[`SCK_BIT_PORT_C];
      keep_vec[7]  = stop_clock_keep_first[`SCK_BIT_PORT_D];
      keep_vec[8]  = stop_clock_keep_first[`SCK_BIT_PORT_E];
      keep_vec[9]  = stop_clock_keep_first[`SCK_BIT_PORT_F];
      keep_vec[10] = stop_clock_keep_second[`SCK_BIT_CONVERTER_B];
      keep_vec[11] = stop_clock_keep_second[`SCK_BIT_CONVERTER_A];
      keep_vec[12] = stop_clock_keep_second[`SCK_BIT_SERIAL_IF0];
      keep_vec[13] = stop_clock_keep_second[`SCK_BIT_SERIAL_IF1];
      keep_vec[14] = stop_clock_keep_second[`SCK_BIT_QUEUED_SPI0];
   end

   // ------------------------------------------------------------------
   // power mode
   // ------------------------------------------------------------------
   // wake only from a peripheral that is actually still clocked
   assign next_wake = |(PERIPH_IRQ_I & CLK_GATE_EN_O);

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         mode <= sck_pkg::SCK_RUN;
      else
      begin
         case (mode)
            sck_pkg::SCK_RUN:
               if (STOP_REQ_I)
                  mode <= sck_pkg::SCK_STOP;
            sck_pkg::SCK_STOP:
               if (next_wake)
                  mode <= sck_pkg::SCK_WAKE;
            sck_pkg::SCK_WAKE:
               mode <= sck_pkg::SCK_RUN;
            default:
               mode <= sck_pkg::SCK_RUN;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         STOP_MODE_O <= 1'b0;
         WAKEUP_O    <= 1'b0;
      end
      else
      begin
         STOP_MODE_O <= (mode == sck_pkg::SCK_STOP) && !next_wake;
         WAKEUP_O    <= (mode == sck_pkg::SCK_STOP) && next_wake;
      end
   end

   // ------------------------------------------------------------------
   // clock gates and access blocking
   // ------------------------------------------------------------------
   // gate and access enable follow the gate of the current cycle, so a bus
   // access never completes to a module whose clock is off
   genvar g;
   generate
      for (g = 0; g < NUM_PERIPH; g++)
      begin : gen_gate
         assign next_gate[g] = PERIPHERAL_CLOCK_ENABLE_I[g] &&
                               ((mode != sck_pkg::SCK_STOP) || keep_vec[g]);
      end
   endgenerate

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         CLK_GATE_EN_O      <= '0;
         PERIPH_ACCESS_EN_O <= '0;
      end
      else
      begin
         CLK_GATE_EN_O      <= next_gate;
         PERIPH_ACCESS_EN_O <= next_gate & PERIPH_SEL_I;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   chk_enable_priority: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !PERIPHERAL_CLOCK_ENABLE_I[0] |=> !CLK_GATE_EN_O[0])
      else $error("gate on while clock enable low");
   chk_stop_gating: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (mode == sck_pkg::SCK_STOP) && !stop_clock_keep_first[`SCK_BIT_PORT_E] |=> !CLK_GATE_EN_O[8])
      else $error("port e clocked in stop without keep");
   chk_keep_holds: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (mode == sck_pkg::SCK_STOP) && keep_vec[12] && PERIPHERAL_CLOCK_ENABLE_I[12] |=> CLK_GATE_EN_O[12])
      else $error("kept serial if0 lost its clock");
   chk_run_clocked: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (mode == sck_pkg::SCK_RUN) && PERIPHERAL_CLOCK_ENABLE_I[14] |=> CLK_GATE_EN_O[14])
      else $error("enabled peripheral not clocked in run");
   chk_access_block: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (PERIPH_ACCESS_EN_O & ~CLK_GATE_EN_O) == '0)
      else $error("access granted to gated peripheral");
   chk_wake_return: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (mode == sck_pkg::SCK_STOP) && next_wake |=> WAKEUP_O ##1 (mode == sck_pkg::SCK_RUN))
      else $error("kept peripheral irq did not wake");
   chk_reserved_zero: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      BUS_WR_I && hit_second |=> (stop_clock_keep_second[15] == 1'b0) && (stop_clock_keep_second[10] == 1'b0))
      else $error("reserved bit of second register set");
   chk_first_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      BUS_WR_I && hit_first |=> stop_clock_keep_first == ($past(BUS_WDATA_I) & `SCK_MASK_FIRST))
      else $error("first register write not stored");
   chk_read_second: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      BUS_SEL_I && !BUS_WR_I && (BUS_ADDR_I == `SCK_OFS_KEEP_SECOND) |=>
         BUS_ACK_O && (BUS_RDATA_O == $past(stop_clock_keep_second)))
      else $error("second register read mismatch");

endmodule

/* File: verif/test_stop_mode_clock_keep_gating.sv */
// self-checking testbench of the stop-mode clock keep block
`timescale 1ns/10ps
`include "sck_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module test_stop_mode_clock_keep_gating;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   logic        clk;
   logic        rst_n;
   logic        sel;
   logic        wr;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;
   logic        stop_req;
   logic [14:0] irq;
   logic        stop_mode;
   logic        wakeup;
   logic [14:0] clk_en;
   logic [14:0] psel;
   logic [14:0] gate;
   logic [14:0] acc_en;
   int          num_errors;
   int          checked;
   int          cycles;
   logic [16:0] rd;
   logic [14:0] en;
   logic [14:0] exp_gate;

   sck_stop_keep u_sck_stop_keep (
      .SYS_CLK_I                 (clk),
      .RST_N_I                   (rst_n),
      .BUS_SEL_I                 (sel),
      .BUS_WR_I                  (wr),
      .BUS_ADDR_I                (addr),
      .BUS_WDATA_I               (wdata),
      .BUS_RDATA_O               (rdata),
      .BUS_ACK_O                 (ack),
      .STOP_REQ_I                (stop_req),
      .PERIPH_IRQ_I              (irq),
      .STOP_MODE_O               (stop_mode),
      .WAKEUP_O                  (wakeup),
      .PERIPHERAL_CLOCK_ENABLE_I (clk_en),
      .PERIPH_SEL_I              (psel),
      .CLK_GATE_EN_O             (gate),
      .PERIPH_ACCESS_EN_O        (acc_en)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // hang guard: whole run needs about 60 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         end_sim();
      end
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one-cycle strobe; returns {ack, rdata} seen in the answer cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [16:0] r);
      @(posedge clk);
      #1;
      sel = 1'b1;
      wr = w;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      sel = 1'b0;
      r = {ack, rdata};
   endtask

   // register bits reordered into peripheral index order
   function automatic logic [14:0] keep_vec(input logic [15:0] f, input logic [15:0] s);
      return {s[9], s[11], s[12], s[13], s[14], f[1], f[2], f[3], f[4], f[5], f[6], f[12], f[13], f[14], f[15]};
   endfunction

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic regs_test();
      bus(1'b0, `SCK_OFS_KEEP_FIRST, 16'h0000, rd);
      `CHK("first reset", {1'b1, 16'h0000}, rd)
      bus(1'b0, `SCK_OFS_KEEP_SECOND, 16'h0000, rd);
      `CHK("second reset", {1'b1, 16'h0000}, rd)
      bus(1'b1, `SCK_OFS_KEEP_FIRST, 16'hFFFF, rd);
      bus(1'b1, `SCK_OFS_KEEP_SECOND, 16'hFFFF, rd);
      bus(1'b0, `SCK_OFS_KEEP_FIRST, 16'h0000, rd);
      `CHK("first ones", {1'b1, 16'hF07E}, rd)
      bus(1'b0, `SCK_OFS_KEEP_SECOND, 16'h0000, rd);
      `CHK("second ones", {1'b1, 16'h7A00}, rd)
      bus(1'b0, 8'h12, 16'h0000, rd);
      `CHK("unmapped", {1'b1, 16'h0000}, rd)
   endtask

   task automatic run_test();
      en = 15'h5AA5;
      clk_en = en;
      psel = 15'h7FFF;
      wait_cyc(3);
      `CHK("run gates", en, gate)
      wait_cyc(1);
      `CHK("run access", en, acc_en)
      psel = 15'h00FF;
      wait_cyc(2);
      `CHK("select access", en & 15'h00FF, acc_en)
      psel = 15'h7FFF;
   endtask

   task automatic stop_test();
      // keep set includes the wakeup source used below (timer A ch0)
      bus(1'b1, `SCK_OFS_KEEP_FIRST, 16'h900A, rd);
      bus(1'b1, `SCK_OFS_KEEP_SECOND, 16'h5200, rd);
      en = 15'h7DBF;
      clk_en = en;
      exp_gate = en & keep_vec(16'h900A, 16'h5200);
      stop_req = 1'b1; // peripherals outside the keep set raise nothing here
      wait_cyc(1);
      stop_req = 1'b0;
      wait_cyc(4);
      `CHK("stop mode", 1'b1, stop_mode)
      `CHK("stop gates", exp_gate, gate)
      `CHK("stop access", exp_gate, acc_en)
      // gated peripheral (port B) raises irq: must be ignored
      irq = 15'h0020;
      repeat (3)
      begin
         wait_cyc(1);
         `CHK("gated irq", 2'b10, {stop_mode, wakeup})
      end
      irq = 15'h0001;
      wait_cyc(1);
      `CHK("wake pulse", 2'b01, {stop_mode, wakeup})
      irq = 15'h0000;
      wait_cyc(1);
      `CHK("wake end", 1'b0, wakeup)
      wait_cyc(3);
      `CHK("run again", en, gate)
   endtask

   initial
   begin
      rst_n = 1'b0;
      sel = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      stop_req = 1'b0;
      irq = 15'h0000;
      clk_en = 15'h0000;
      psel = 15'h0000;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      wait_cyc(20);
      rst_n = 1'b1;
      regs_test();
      run_test();
      stop_test();
      end_sim();
   end
endmodule
